// File: shared/pfs_regs.svh
`ifndef PFS_REGS_SVH
`define PFS_REGS_SVH
// apb byte offsets, one aligned word per register
`define PFS_OFS_A_HIGH 12'h000
`define PFS_OFS_A_LOW 12'h004
`define PFS_OFS_B_DIR 12'h008
`define PFS_OFS_MODE 12'h00C
`define PFS_OFS_STATUS 12'h010
// writable bit masks, everything else reads zero
`define PFS_MASK_A_HIGH 16'h005F
`define PFS_MASK_A_LOW 16'hFD75
`define PFS_MASK_B_DIR 16'h03FF
`define PFS_MASK_B_REDUCED 16'h03FC
`define PFS_MASK_MODE 16'h0001
// reset values
`define PFS_RST_A_HIGH 16'h0000
`define PFS_RST_A_LOW 16'h0000
`define PFS_RST_B_DIR 16'h0000
`define PFS_RST_MODE 16'h0000
// field positions in the high function register
`define PFS_P11_BIT 6
`define PFS_P10_BIT 4
`define PFS_P9_LSB 2
`define PFS_P8_LSB 0
// field positions in the low function register
`define PFS_P7_LSB 14
`define PFS_P6_LSB 12
`define PFS_P5_LSB 10
`define PFS_P4_BIT 8
`define PFS_P3_BIT 6
`define PFS_P2_LSB 4
`define PFS_P1_BIT 2
`define PFS_P0_BIT 0
// mode register: single-chip operation
`define PFS_SINGLE_BIT 0
`endif

// File: shared/pfs_pkg.sv
`default_nettype none

package pfs_pkg;
    // two-bit pin function codes
    typedef enum logic [1:0] {
        PFS_FN_GPIO = 2'h0,
        PFS_FN_ALT1 = 2'h1,
        PFS_FN_ALT2 = 2'h2,
        PFS_FN_ALT3 = 2'h3
    } pfs_func_e;

    // signals from on-chip peripherals toward the pins
    typedef struct packed {
        logic [3:0] chip_select_out;
        logic [1:0] serial_clock_out;
        logic [1:0] serial_clock_oe;
        logic [1:0] serial_tx;
    } pfs_periph_out_s;

    // signals from the pins toward on-chip peripherals
    typedef struct packed {
        logic [3:0] timer_ext_clock;
        logic [3:0] ext_interrupt_in;
        logic [1:0] dma_request_in;
        logic [1:0] serial_clock_in;
        logic [1:0] serial_rx;
    } pfs_periph_in_s;
endpackage : pfs_pkg

`default_nettype wire

// File: rtl/pfs_top.sv
// How it works
// - pin11 bit6: gpio or chip select 1
// - pin10 bit4: gpio or chip select 0
// - reserved control bits read zero
// - pin9 field: gpio, timer clock d, ext_interrupt_in_3
// - pin8 field: gpio, timer clock c, ext_interrupt_in_2
// - pin7 field: gpio, timer clock b, cs3
// - pin6 field: gpio, timer clock a, cs2
// - pin5 field: gpio, serial_clock_ch1, dma_request_in_1, ext_interrupt_in_1
// - pin4 bit8: gpio or transmit ch1
// - pin3 bit6: gpio or receive ch1
// - pin2 field: gpio, serial_clock_ch0, dma_request_in_0, ext_interrupt_in_0
// - single-chip dma request code means gpio
// - pin1 bit2: gpio or transmit ch0
// - pin0 bit0: gpio or receive ch0
// - port b direction bit: one output
// - direction acts on gpio pins only
// - direction register clears on power-on reset
// - reduced variant direction bits 1:0 zero
// - low function register clears on reset
`include "pfs_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pfs_top #(
    parameter bit REDUCED_PINS = 1'b0,
    parameter int PA_PINS = 12,
    parameter int PB_PINS = 10
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PA_PINS-1:0] pa_pin_in,
    output logic [PA_PINS-1:0] pa_pin_out,
    output logic [PA_PINS-1:0] pa_pin_oe,
    input wire logic [PA_PINS-1:0] pa_gpio_out,
    input wire logic [PA_PINS-1:0] pa_gpio_dir,
    output logic [PA_PINS-1:0] pa_gpio_in,
    input wire logic [PB_PINS-1:0] pb_pin_in,
    output logic [PB_PINS-1:0] pb_pin_out,
    output logic [PB_PINS-1:0] pb_pin_oe,
    input wire logic [PB_PINS-1:0] pb_gpio_out,
    input wire logic [PB_PINS-1:0] pb_gpio_sel,
    output logic [PB_PINS-1:0] pb_gpio_in,
    input wire pfs_pkg::pfs_periph_out_s periph_out,
    output pfs_pkg::pfs_periph_in_s periph_in
);
    import pfs_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // register state
    logic [15:0] a_high_reg; // pins 11..8 function select
    logic [15:0] a_low_reg; // pins 7..0 function select
    logic [15:0] b_dir_reg; // port b direction
    logic [15:0] mode_reg; // operating mode
    logic [15:0] b_dir_mask; // variant dependent writable bits
    logic [PA_PINS-1:0] pa_meta_reg; // first sync stage only
    logic [PA_PINS-1:0] pa_sync_reg; // synchronised port a pins
    logic [PB_PINS-1:0] pb_meta_reg; // first sync stage only
    logic [PB_PINS-1:0] pb_sync_reg; // synchronised port b pins
    logic single_chip; // no external bus
    logic wr_en; // apb write in access phase
    logic rd_setup; // apb setup cycle
    logic [15:0] wmask; // byte lanes of the low half
    logic [15:0] rd_word; // decoded read value
    logic rd_hit; // address maps a register

    // decoded function per pin
    pfs_func_e code9, code8, code7, code6, code5, code2;
    logic sel_cs0, sel_cs1, sel_cs2, sel_cs3;
    logic sel_timer_ext_clock_a, sel_timer_ext_clock_b, sel_timer_ext_clock_c, sel_timer_ext_clock_d;
    logic sel_ext_interrupt_in_0, sel_ext_interrupt_in_1, sel_ext_interrupt_in_2, sel_ext_interrupt_in_3;
    logic sel_serial_clock_ch0, sel_serial_clock_ch1, sel_dma_request_in_0, sel_dma_request_in_1;
    logic sel_tx0, sel_tx1, sel_rx0, sel_rx1;
    logic [PA_PINS-1:0] pa_is_gpio; // pin runs as general i/o
    logic [PA_PINS-1:0] alt_oe; // peripheral drives the pin
    logic [PA_PINS-1:0] alt_out; // peripheral output level

    assign single_chip = mode_reg[`PFS_SINGLE_BIT];
    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign b_dir_mask = REDUCED_PINS ? `PFS_MASK_B_REDUCED
                                     : `PFS_MASK_B_DIR;

    ////////////////////////////////////////////////////////////////////
    // apb register writes, taken in the access phase
    // reserved bits masked
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            a_high_reg <= `PFS_RST_A_HIGH;
        end else if (wr_en && paddr == `PFS_OFS_A_HIGH) begin
            a_high_reg <= (a_high_reg & ~wmask)
                | (pwdata[15:0] & wmask & `PFS_MASK_A_HIGH);
        end
    end

    // only power-on reset clears; otherwise only apb writes to its offset change it
    // cleared on reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            a_low_reg <= `PFS_RST_A_LOW;
        end else if (wr_en && paddr == `PFS_OFS_A_LOW) begin
            a_low_reg <= (a_low_reg & ~wmask)
                | (pwdata[15:0] & wmask & `PFS_MASK_A_LOW);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            b_dir_reg <= `PFS_RST_B_DIR;
        end else if (wr_en && paddr == `PFS_OFS_B_DIR) begin
            b_dir_reg <= (b_dir_reg & ~wmask)
                | (pwdata[15:0] & wmask & b_dir_mask);
        end
    end

    // operating mode; a strap would normally load this
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode_reg <= `PFS_RST_MODE;
        end else if (wr_en && paddr == `PFS_OFS_MODE) begin
            mode_reg <= (mode_reg & ~wmask)
                | (pwdata[15:0] & wmask & `PFS_MASK_MODE);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read decode; unmapped addresses answer with an error
    always_comb begin
        rd_word = 16'h0000;
        rd_hit = 1'b1;
        case (paddr)
            `PFS_OFS_A_HIGH: rd_word = a_high_reg;
            `PFS_OFS_A_LOW: rd_word = a_low_reg;
            `PFS_OFS_B_DIR: rd_word = b_dir_reg;
            `PFS_OFS_MODE: rd_word = mode_reg;
            // live function map: one means general i/o
            `PFS_OFS_STATUS: rd_word = {4'h0, pa_is_gpio};
            default: rd_hit = 1'b0;
        endcase
    end

    // read data captured at setup so the access phase needs no wait
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            prdata <= {16'h0000, rd_word};
            pslverr <= ~rd_hit;
        end
    end

    // zero wait state slave, ready from the first cycle after reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // function decode
    always_comb begin
        code9 = pfs_func_e'(a_high_reg[`PFS_P9_LSB +: 2]);
        code8 = pfs_func_e'(a_high_reg[`PFS_P8_LSB +: 2]);
        code7 = pfs_func_e'(a_low_reg[`PFS_P7_LSB +: 2]);
        code6 = pfs_func_e'(a_low_reg[`PFS_P6_LSB +: 2]);
        code5 = pfs_func_e'(a_low_reg[`PFS_P5_LSB +: 2]);
        code2 = pfs_func_e'(a_low_reg[`PFS_P2_LSB +: 2]);
        sel_cs1 = a_high_reg[`PFS_P11_BIT] & ~single_chip;
        sel_cs0 = a_high_reg[`PFS_P10_BIT] & ~single_chip;
        // pin9 codes; code 11 falls to gpio
        sel_timer_ext_clock_d = (code9 == PFS_FN_ALT1);
        sel_ext_interrupt_in_3 = (code9 == PFS_FN_ALT2);
        sel_timer_ext_clock_c = (code8 == PFS_FN_ALT1);
        sel_ext_interrupt_in_2 = (code8 == PFS_FN_ALT2);
        sel_timer_ext_clock_b = (code7 == PFS_FN_ALT1);
        sel_cs3 = (code7 == PFS_FN_ALT2) & ~single_chip;
        sel_timer_ext_clock_a = (code6 == PFS_FN_ALT1);
        sel_cs2 = (code6 == PFS_FN_ALT2) & ~single_chip;
        sel_serial_clock_ch1 = (code5 == PFS_FN_ALT1);
        sel_ext_interrupt_in_1 = (code5 == PFS_FN_ALT3);
        sel_serial_clock_ch0 = (code2 == PFS_FN_ALT1);
        sel_ext_interrupt_in_0 = (code2 == PFS_FN_ALT3);
        sel_dma_request_in_1 = (code5 == PFS_FN_ALT2) & ~single_chip;
        sel_dma_request_in_0 = (code2 == PFS_FN_ALT2) & ~single_chip;
        sel_tx1 = a_low_reg[`PFS_P4_BIT];
        sel_rx1 = a_low_reg[`PFS_P3_BIT];
        sel_tx0 = a_low_reg[`PFS_P1_BIT];
        sel_rx0 = a_low_reg[`PFS_P0_BIT];
    end

    // per pin routing; any pin not claimed stays general i/o
    // reserved codes gpio
    always_comb begin
        pa_is_gpio[11] = ~sel_cs1;
        pa_is_gpio[10] = ~sel_cs0;
        pa_is_gpio[9] = ~(sel_timer_ext_clock_d | sel_ext_interrupt_in_3);
        pa_is_gpio[8] = ~(sel_timer_ext_clock_c | sel_ext_interrupt_in_2);
        pa_is_gpio[7] = ~(sel_timer_ext_clock_b | sel_cs3);
        pa_is_gpio[6] = ~(sel_timer_ext_clock_a | sel_cs2);
        pa_is_gpio[5] = ~(sel_serial_clock_ch1 | sel_dma_request_in_1 | sel_ext_interrupt_in_1);
        pa_is_gpio[4] = ~sel_tx1;
        pa_is_gpio[3] = ~sel_rx1;
        pa_is_gpio[2] = ~(sel_serial_clock_ch0 | sel_dma_request_in_0 | sel_ext_interrupt_in_0);
        pa_is_gpio[1] = ~sel_tx0;
        pa_is_gpio[0] = ~sel_rx0;
        // outputs that a peripheral drives
        alt_oe = '0;
        alt_out = '0;
        alt_oe[11] = sel_cs1;
        alt_out[11] = periph_out.chip_select_out[1];
        alt_oe[10] = sel_cs0;
        alt_out[10] = periph_out.chip_select_out[0];
        alt_oe[7] = sel_cs3;
        alt_out[7] = periph_out.chip_select_out[3];
        alt_oe[6] = sel_cs2;
        alt_out[6] = periph_out.chip_select_out[2];
        alt_oe[5] = sel_serial_clock_ch1 & periph_out.serial_clock_oe[1];
        alt_out[5] = periph_out.serial_clock_out[1];
        alt_oe[4] = sel_tx1;
        alt_out[4] = periph_out.serial_tx[1];
        alt_oe[2] = sel_serial_clock_ch0 & periph_out.serial_clock_oe[0];
        alt_out[2] = periph_out.serial_clock_out[0];
        alt_oe[1] = sel_tx0;
        alt_out[1] = periph_out.serial_tx[0];
    end

    ////////////////////////////////////////////////////////////////////
    // two-stage synchronisers on every pin input
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pa_meta_reg <= '0;
            pa_sync_reg <= '0;
            pb_meta_reg <= '0;
            pb_sync_reg <= '0;
        end else begin
            pa_meta_reg <= pa_pin_in;
            pa_sync_reg <= pa_meta_reg;
            pb_meta_reg <= pb_pin_in;
            pb_sync_reg <= pb_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered pin drive, one cycle behind the selection
    genvar gi;
    generate
        for (gi = 0; gi < PA_PINS; gi++) begin : g_pa
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    pa_pin_out[gi] <= 1'b0;
                    pa_pin_oe[gi] <= 1'b0;
                    pa_gpio_in[gi] <= 1'b0;
                end else begin
                    pa_pin_out[gi] <= pa_is_gpio[gi] ? pa_gpio_out[gi]
                                                     : alt_out[gi];
                    pa_pin_oe[gi] <= pa_is_gpio[gi] ? pa_gpio_dir[gi]
                                                    : alt_oe[gi];
                    pa_gpio_in[gi] <= pa_sync_reg[gi];
                end
            end
        end
        for (gi = 0; gi < PB_PINS; gi++) begin : g_pb
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    pb_pin_out[gi] <= 1'b0;
                    pb_pin_oe[gi] <= 1'b0;
                    pb_gpio_in[gi] <= 1'b0;
                end else begin
                    pb_pin_out[gi] <= pb_gpio_out[gi];
                    pb_pin_oe[gi] <= b_dir_reg[gi] & pb_gpio_sel[gi];
                    pb_gpio_in[gi] <= pb_sync_reg[gi];
                end
            end
        end
    endgenerate

    // inputs toward peripherals; deselected inputs sit idle
    // (active-low request lines idle high, data lines idle high)
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            periph_in <= '{timer_ext_clock: 4'h0,
                           ext_interrupt_in: 4'hF,
                           dma_request_in: 2'h3,
                           serial_clock_in: 2'h0,
                           serial_rx: 2'h3};
        end else begin
            periph_in.timer_ext_clock <= {sel_timer_ext_clock_d & pa_sync_reg[9],
                sel_timer_ext_clock_c & pa_sync_reg[8], sel_timer_ext_clock_b & pa_sync_reg[7],
                sel_timer_ext_clock_a & pa_sync_reg[6]};
            periph_in.ext_interrupt_in <= {~sel_ext_interrupt_in_3 | pa_sync_reg[9],
                ~sel_ext_interrupt_in_2 | pa_sync_reg[8], ~sel_ext_interrupt_in_1 | pa_sync_reg[5],
                ~sel_ext_interrupt_in_0 | pa_sync_reg[2]};
            periph_in.dma_request_in <= {~sel_dma_request_in_1 | pa_sync_reg[5],
                ~sel_dma_request_in_0 | pa_sync_reg[2]};
            periph_in.serial_clock_in <= {sel_serial_clock_ch1 & pa_sync_reg[5],
                sel_serial_clock_ch0 & pa_sync_reg[2]};
            periph_in.serial_rx <= {~sel_rx1 | pa_sync_reg[3],
                ~sel_rx0 | pa_sync_reg[0]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // assertions
    cs1_route_a: assert property (@(posedge mclk) disable iff (!rst_n)
        sel_cs1 |=> pa_pin_oe[11] && pa_pin_out[11] ==
            $past(periph_out.chip_select_out[1]))
        else $error("pin11 not driving chip select 1");
    cs0_route_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (a_high_reg[`PFS_P10_BIT] && !single_chip) |=> pa_pin_oe[10] &&
            pa_pin_out[10] == $past(periph_out.chip_select_out[0]))
        else $error("pin10 chip select lost");
    resv_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (a_low_reg & ~`PFS_MASK_A_LOW) == 16'h0000 &&
        (a_high_reg & ~`PFS_MASK_A_HIGH) == 16'h0000)
        else $error("reserved function bits set");
    pin9_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
        code9 == PFS_FN_ALT2 |=> periph_in.ext_interrupt_in[3] ==
            $past(pa_sync_reg[9]))
        else $error("pin9 irq path broken");
    pin8_resv_a: assert property (@(posedge mclk) disable iff (!rst_n)
        code8 == PFS_FN_ALT3 |-> pa_is_gpio[8])
        else $error("reserved code left pin8 non gpio");
    dreq_single_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (single_chip && code5 == PFS_FN_ALT2) |->
            pa_is_gpio[5] ##1 periph_in.dma_request_in[1])
        else $error("dma request active in single-chip");
    pb_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        pb_pin_oe != '0 |-> ($past(b_dir_reg[PB_PINS-1:0]) &
            $past(pb_gpio_sel)) == pb_pin_oe)
        else $error("port b enable not from direction and gpio");
    pb_reset_a: assert property (@(posedge mclk)
        !rst_n |=> b_dir_reg == 16'h0000 && a_low_reg == 16'h0000)
        else $error("registers not cleared by reset");
    pb_reduced_a: assert property (@(posedge mclk) disable iff (!rst_n)
        REDUCED_PINS |-> b_dir_reg[1:0] == 2'h0)
        else $error("reduced variant direction bits set");
    tx0_route_a: assert property (@(posedge mclk) disable iff (!rst_n)
        sel_tx0 |=> pa_pin_oe[1] && pa_pin_out[1] ==
            $past(periph_out.serial_tx[0]))
        else $error("pin1 not transmitting");
endmodule : pfs_top

`default_nettype wire

// File: dv/pfs_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// outside world at the port pins: board level meets device drive
module pfs_pin_model (
    input wire logic [11:0] pa_pin_out,
    input wire logic [11:0] pa_pin_oe,
    input wire logic [11:0] pa_ext,
    output logic [11:0] pa_pin_in,
    input wire logic [9:0] pb_pin_out,
    input wire logic [9:0] pb_pin_oe,
    input wire logic [9:0] pb_ext,
    output logic [9:0] pb_pin_in
);
    // a driven pin shows the device level, an idle one the board level
    // no pull resistors modelled, so the board level is set per scenario
    assign pa_pin_in = (pa_pin_oe & pa_pin_out) | (~pa_pin_oe & pa_ext);
    assign pb_pin_in = (pb_pin_oe & pb_pin_out) | (~pb_pin_oe & pb_ext);
endmodule : pfs_pin_model

`default_nettype wire

// File: dv/port_a_b_pin_function_select_test.sv
`timescale 1ns/1ps
`default_nettype none

module port_a_b_pin_function_select_test;
    import pfs_pkg::*;
    localparam logic [11:0] AH = 12'h000; // high function register
    localparam logic [11:0] AL = 12'h004; // low function register
    localparam int GP = 0; // pin expected as gpio
    localparam int OUTF = 1; // pin driven by a peripheral
    localparam int INF = 2; // pin feeding a peripheral input
    logic mclk = 1'b0;
    logic rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [11:0] pa_pin_in, pa_pin_out, pa_pin_oe, pa_gpio_in;
    logic [11:0] pa_gpio_out, pa_gpio_dir, pa_ext;
    logic [9:0] pb_pin_in, pb_pin_out, pb_pin_oe, pb_gpio_in;
    logic [9:0] pb_gpio_out, pb_gpio_sel, pb_ext;
    pfs_periph_out_s periph_out;
    pfs_periph_in_s periph_in;
    logic [13:0] pin_vec; // flat view of peripheral inputs
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    assign pin_vec = periph_in;

    pfs_top u_pfs_top (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pa_pin_in(pa_pin_in), .pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe),
        .pa_gpio_out(pa_gpio_out), .pa_gpio_dir(pa_gpio_dir),
        .pa_gpio_in(pa_gpio_in), .pb_pin_in(pb_pin_in),
        .pb_pin_out(pb_pin_out), .pb_pin_oe(pb_pin_oe),
        .pb_gpio_out(pb_gpio_out), .pb_gpio_sel(pb_gpio_sel),
        .pb_gpio_in(pb_gpio_in), .periph_out(periph_out),
        .periph_in(periph_in));

    pfs_pin_model u_pfs_pin_model (.pa_pin_out(pa_pin_out),
        .pa_pin_oe(pa_pin_oe), .pa_ext(pa_ext), .pa_pin_in(pa_pin_in),
        .pb_pin_out(pb_pin_out), .pb_pin_oe(pb_pin_oe), .pb_ext(pb_ext),
        .pb_pin_in(pb_pin_in));

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        forever #12.5 mclk = ~mclk;
    end

    // a stuck handshake would otherwise run forever
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            $display("Error timeout expected end seen hang");
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // compare and bus tasks
    task chk_word(input string name, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask : chk_word

    task chk_bit(input string name, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %b seen %b", name, e, g);
        end
    endtask : chk_bit

    // one apb transfer, held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [3:0] s);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        // no own limit: only the bench timeout ends a stuck wait
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task do_reset;
        rst_n <= 1'b0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    // the four control registers read zero after a power-on reset
    task t_reset_vals;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0, 4'hF);
            chk_word("reset value", 32'h0, rd);
            chk_bit("reset err", 1'b0, err);
        end
    endtask : t_reset_vals

    // reserved bits, byte strobes and an unmapped place
    task t_regs;
        logic [31:0] msk [4];
        msk = '{32'h005F, 32'hFD75, 32'h03FF, 32'h0001};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'(4 * i), 32'hFFFF_FFFF, 4'hF);
            apb(1'b0, 12'(4 * i), 32'h0, 4'hF);
            chk_word("writable bits", msk[i], rd);
        end
        apb(1'b1, AL, 32'h0, 4'h1);
        apb(1'b0, AL, 32'h0, 4'hF);
        chk_word("lane write", 32'hFD00, rd);
        apb(1'b1, 12'h014, 32'hFFFF_FFFF, 4'hF);
        chk_bit("unmapped write err", 1'b1, err);
        apb(1'b0, 12'h014, 32'h0, 4'hF);
        chk_bit("unmapped read err", 1'b1, err);
        chk_word("unmapped read", 32'h0, rd);
    endtask : t_regs

    // one pin set to one code, then its drive or routing judged
    task run_case(input logic [11:0] a, input logic [15:0] v, input logic m,
                  input int pin, input int kind, input int bi, input logic lvl);
        apb(1'b1, 12'h00C, {31'h0, m}, 4'hF);
        apb(1'b1, a, {16'h0, v}, 4'hF);
        pa_ext <= lvl ? (12'h1 << pin) : ~(12'h1 << pin);
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        if (kind == INF) begin
            chk_bit("routed input", lvl, pin_vec[bi]);
            chk_bit("gpio in", lvl, pa_gpio_in[pin]);
            chk_bit("input pin oe", 1'b0, pa_pin_oe[pin]);
        end else begin
            chk_bit("pin oe", 1'b1, pa_pin_oe[pin]);
            chk_bit("pin out", kind == OUTF, pa_pin_out[pin]);
        end
    endtask : run_case

    // direction bits drive only pins whose function is gpio
    task t_portb;
        // previous scenario ended on a falling edge
        @(posedge mclk);
        pb_gpio_sel <= 10'h3FF;
        pb_gpio_out <= 10'h3FF;
        pb_ext <= 10'h000;
        // live map: pin0 receives, pin8 reserved code stays gpio
        apb(1'b0, 12'h010, 32'h0, 4'hF);
        chk_word("gpio map", 32'hFFE, rd);
        apb(1'b1, 12'h008, 32'h0155, 4'hF);
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk_word("pb oe", 32'h155, {22'h0, pb_pin_oe});
        chk_word("pb gpio in", 32'h155, {22'h0, pb_gpio_in});
        chk_word("pb out", 32'h3FF, {22'h0, pb_pin_out});
        @(posedge mclk);
        pb_gpio_sel <= 10'h0F0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk_word("pb oe masked", 32'h050, {22'h0, pb_pin_oe});
    endtask : t_portb

    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        periph_out = '1; // every peripheral drives high
        pa_gpio_out = 12'h000; // gpio drives low, so the source shows
        pa_gpio_dir = 12'hFFF;
        pa_ext = 12'h000;
        pb_gpio_out = 10'h000;
        pb_gpio_sel = 10'h000;
        pb_ext = 10'h000;
        do_reset();
        t_reset_vals();
        t_regs();
        do_reset();
        t_reset_vals();
        run_case(AH, 16'h0040, 1'b0, 11, OUTF, 0, 1'b0);
        run_case(AH, 16'h0040, 1'b1, 11, GP, 0, 1'b0);
        run_case(AH, 16'h0010, 1'b0, 10, OUTF, 0, 1'b0);
        run_case(AH, 16'h0010, 1'b1, 10, GP, 0, 1'b0);
        run_case(AH, 16'h0004, 1'b0, 9, INF, 13, 1'b1);
        run_case(AH, 16'h0008, 1'b0, 9, INF, 9, 1'b0);
        run_case(AH, 16'h000C, 1'b0, 9, GP, 0, 1'b0);
        run_case(AH, 16'h0001, 1'b0, 8, INF, 12, 1'b1);
        run_case(AH, 16'h0002, 1'b0, 8, INF, 8, 1'b0);
        run_case(AH, 16'h0003, 1'b0, 8, GP, 0, 1'b0);
        run_case(AL, 16'h4000, 1'b0, 7, INF, 11, 1'b1);
        run_case(AL, 16'h8000, 1'b0, 7, OUTF, 0, 1'b0);
        run_case(AL, 16'h8000, 1'b1, 7, GP, 0, 1'b0);
        run_case(AL, 16'hC000, 1'b0, 7, GP, 0, 1'b0);
        run_case(AL, 16'h1000, 1'b0, 6, INF, 10, 1'b1);
        run_case(AL, 16'h2000, 1'b0, 6, OUTF, 0, 1'b0);
        run_case(AL, 16'h2000, 1'b1, 6, GP, 0, 1'b0);
        run_case(AL, 16'h3000, 1'b0, 6, GP, 0, 1'b0);
        run_case(AL, 16'h0400, 1'b0, 5, OUTF, 0, 1'b0);
        run_case(AL, 16'h0800, 1'b0, 5, INF, 5, 1'b0);
        run_case(AL, 16'h0800, 1'b1, 5, GP, 0, 1'b0);
        run_case(AL, 16'h0C00, 1'b0, 5, INF, 7, 1'b0);
        run_case(AL, 16'h0000, 1'b0, 4, GP, 0, 1'b0);
        run_case(AL, 16'h0100, 1'b0, 4, OUTF, 0, 1'b0);
        run_case(AL, 16'h0040, 1'b0, 3, INF, 1, 1'b0);
        run_case(AL, 16'h0010, 1'b0, 2, OUTF, 0, 1'b0);
        run_case(AL, 16'h0020, 1'b0, 2, INF, 4, 1'b0);
        run_case(AL, 16'h0020, 1'b1, 2, GP, 0, 1'b0);
        run_case(AL, 16'h0030, 1'b0, 2, INF, 6, 1'b0);
        run_case(AL, 16'h0004, 1'b0, 1, OUTF, 0, 1'b0);
        run_case(AL, 16'h0001, 1'b0, 0, INF, 0, 1'b0);
        t_portb();
        final_report();
    end
endmodule : port_a_b_pin_function_select_test

`default_nettype wire
